// ==== rtl/spcp_top.sv ====
// Serial target port and command register of the light and distance sensor.
// Assumes open-drain bus wires resolved outside; converters report on the same clock.
`timescale 1ns/1ps
module spcp_top import spcp_pkg::*; #(
  parameter int LP_CYCLES = SPCP_LP_CYCLES,
  parameter logic [7:0] ID_VALUE = 8'h5a // Arbitrary identity value.
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic int_out,
  output logic int_oe_n,
  output logic amb_start,
  output logic dist_start,
  input spcp_res_t amb_res,
  input spcp_res_t dist_res
);

  // ------------------------------------------------------------------
  // Pin synchronisers and bus events
  // ------------------------------------------------------------------
  logic [2:0] scl_q, sda_q; // Bit 0 is the first synchroniser stage.
  logic scl_rise, scl_fall, bus_start, bus_stop;

  // Two stages bring the pins in; the third stage serves only edge detection.
  // Oversampled pins suit bus clocks several times slower than mclk
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  // Start and stop are data edges while the clock is high.
  always_comb begin
    scl_rise = scl_q[1] && !scl_q[2];
    scl_fall = !scl_q[1] && scl_q[2];
    bus_start = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1];
    bus_stop = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1];
  end

  // ------------------------------------------------------------------
  // Register and transfer state
  // ------------------------------------------------------------------
  spcp_state_t st_q, st_d; // Transfer state.
  logic [2:0] bit_q, bit_d; // Bit count within a byte.
  logic [7:0] sh_q, sh_d; // Shift register in both directions.
  logic [4:0] ptr_q, ptr_d; // Register index.
  logic ptr_ok_q, ptr_ok_d; // Index lies in the register window.
  logic sda_oe_n_q, sda_oe_n_d; // Low pulls the data wire.
  spcp_cfg_t cfg_q, cfg_d; // Self-timed configuration.
  logic amb_os_q, amb_os_d, dist_os_q, dist_os_d; // One-shot pulses.
  logic amb_rdy_q, amb_rdy_d, dist_rdy_q, dist_rdy_d; // Data-ready flags.
  logic [15:0] amb_val_q, amb_val_d, dist_val_q, dist_val_d; // Results.
  logic [7:0] mem_q [SPCP_REG_COUNT]; // Plain storage registers.
  logic [7:0] mem_d [SPCP_REG_COUNT];
  logic int_oe_n_q, int_oe_n_d; // Interrupt pull-down enable.
  logic amb_busy, dist_busy; // Conversions in progress.
  logic clr_amb, clr_dist; // Result read strobes.

  // Read-back value of a register index.
  function automatic logic [7:0] read_value(input logic [4:0] idx);
    logic [7:0] v;
    v = mem_q[idx];
    case (idx)
      SPCP_IDX_CMD: v = {1'b1, amb_rdy_q, dist_rdy_q, amb_busy, dist_busy,
                         cfg_q.amb_en, cfg_q.dist_en, cfg_q.selftimed};
      SPCP_IDX_ID: v = ID_VALUE;
      SPCP_IDX_AMB_HI: v = amb_val_q[15:8];
      SPCP_IDX_AMB_LO: v = amb_val_q[7:0];
      SPCP_IDX_DIST_HI: v = dist_val_q[15:8];
      SPCP_IDX_DIST_LO: v = dist_val_q[7:0];
      default: v = mem_q[idx];
    endcase
    return v;
  endfunction

  // Next-state logic of the target port and the registers behind it.
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    ptr_ok_d = ptr_ok_q;
    sda_oe_n_d = sda_oe_n_q;
    cfg_d = cfg_q;
    mem_d = mem_q;
    amb_os_d = 1'b0;
    dist_os_d = 1'b0;
    clr_amb = 1'b0;
    clr_dist = 1'b0;
    if (bus_start) begin
      // A repeated start also lands here, ready for a new address byte.
      st_d = SPCP_ADDR;
      bit_d = 3'h0;
      sda_oe_n_d = 1'b1;
    end else if (bus_stop) begin
      st_d = SPCP_IDLE;
      sda_oe_n_d = 1'b1;
    end else begin
      case (st_q)
        SPCP_ADDR, SPCP_REGA, SPCP_WDATA: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_q[1]};
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              if (st_q == SPCP_ADDR) begin
                st_d = (sh_q[6:0] == SPCP_DEV_ADDR) ? SPCP_ACK_A : SPCP_IDLE;
                sh_d = {7'h0, sda_q[1]};
              end else if (st_q == SPCP_REGA) begin
                ptr_ok_d = (sh_d >= SPCP_REG_BASE) && (sh_d <= SPCP_REG_BASE + 8'(SPCP_IDX_LAST));
                ptr_d = 5'(sh_d - SPCP_REG_BASE);
                st_d = SPCP_ACK_R;
              end else begin
                st_d = SPCP_ACK_W;
                if (ptr_ok_q && ptr_q == SPCP_IDX_CMD) begin
                  cfg_d = '{selftimed: sh_d[SPCP_SELF_BIT], amb_en: sh_d[SPCP_AMB_EN_BIT],
                            dist_en: sh_d[SPCP_DIST_EN_BIT]};
                  amb_os_d = sh_d[SPCP_AMB_OS_BIT] && !sh_d[SPCP_SELF_BIT];
                  dist_os_d = sh_d[SPCP_DIST_OS_BIT] && !sh_d[SPCP_SELF_BIT];
                end else if (ptr_ok_q && (ptr_q > SPCP_IDX_DIST_LO || ptr_q == 5'h2
                             || ptr_q == 5'h3 || ptr_q == 5'h4)) begin
                  mem_d[ptr_q] = sh_d;
                end
              end
            end
          end
        end
        SPCP_ACK_A, SPCP_ACK_R, SPCP_ACK_W: begin
          if (scl_fall) begin
            if (sda_oe_n_q) begin
              sda_oe_n_d = 1'b0;
            end else if (st_q == SPCP_ACK_A && sh_q[0]) begin
              sh_d = ptr_ok_q ? read_value(ptr_q) : 8'h00;
              sda_oe_n_d = sh_d[7];
              bit_d = 3'h0;
              st_d = SPCP_RDATA;
              clr_amb = ptr_ok_q && (ptr_q == SPCP_IDX_AMB_HI || ptr_q == SPCP_IDX_AMB_LO);
              clr_dist = ptr_ok_q && (ptr_q == SPCP_IDX_DIST_HI || ptr_q == SPCP_IDX_DIST_LO);
            end else begin
              sda_oe_n_d = 1'b1;
              bit_d = 3'h0;
              // Only one data byte per write; further bytes are not acknowledged.
              st_d = (st_q == SPCP_ACK_A) ? SPCP_REGA : (st_q == SPCP_ACK_R) ? SPCP_WDATA : SPCP_IDLE;
            end
          end
        end
        SPCP_RDATA: begin
          if (scl_fall) begin
            sh_d = {sh_q[6:0], 1'b0};
            bit_d = bit_q + 3'h1;
            sda_oe_n_d = (bit_q == 3'h7) ? 1'b1 : sh_q[6];
            st_d = (bit_q == 3'h7) ? SPCP_RACK : SPCP_RDATA;
          end
        end
        SPCP_RACK: begin
          // The host's acknowledge is not needed: one byte per read.
          if (scl_rise) begin
            st_d = SPCP_IDLE;
          end
        end
        default: st_d = SPCP_IDLE;
      endcase
    end
    amb_rdy_d = amb_res.done || (amb_rdy_q && !clr_amb);
    dist_rdy_d = dist_res.done || (dist_rdy_q && !clr_dist);
    // Result valid only at conversion end
    amb_val_d = amb_res.done ? amb_res.data : amb_val_q;
    dist_val_d = dist_res.done ? dist_res.data : dist_val_q;
    int_oe_n_d = !(amb_rdy_d || dist_rdy_d);
  end

  // Registers of the port.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= SPCP_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      ptr_q <= 5'h00;
      ptr_ok_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      cfg_q <= '0;
      amb_os_q <= 1'b0;
      dist_os_q <= 1'b0;
      amb_rdy_q <= 1'b0;
      dist_rdy_q <= 1'b0;
      amb_val_q <= 16'h0000;
      dist_val_q <= 16'h0000;
      int_oe_n_q <= 1'b1;
      for (int i = 0; i < SPCP_REG_COUNT; i++) begin
        mem_q[i] <= SPCP_STORE_RESET;
      end
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      ptr_ok_q <= ptr_ok_d;
      sda_oe_n_q <= sda_oe_n_d;
      cfg_q <= cfg_d;
      amb_os_q <= amb_os_d;
      dist_os_q <= dist_os_d;
      amb_rdy_q <= amb_rdy_d;
      dist_rdy_q <= dist_rdy_d;
      amb_val_q <= amb_val_d;
      dist_val_q <= dist_val_d;
      int_oe_n_q <= int_oe_n_d;
      mem_q <= mem_d;
    end
  end

  // Open-drain pins only ever drive low, so the data level is a constant.
  assign sda_out = 1'b0;
  assign int_out = 1'b0;
  assign sda_oe_n = sda_oe_n_q;
  assign int_oe_n = int_oe_n_q;

  // ------------------------------------------------------------------
  // Scheduler
  // ------------------------------------------------------------------
  spcp_seq #(.LP_CYCLES(LP_CYCLES)) u_seq (
    .mclk(mclk), .rst(rst), .cfg(cfg_q), .amb_os(amb_os_q), .dist_os(dist_os_q),
    .amb_done(amb_res.done), .dist_done(dist_res.done), .amb_start(amb_start), .dist_start(dist_start),
    .amb_busy(amb_busy), .dist_busy(dist_busy)
  );

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  wrong_addr_a: assert property (st_q == SPCP_ADDR && scl_rise && bit_q == 3'h7 && !bus_start && !bus_stop
    && sh_q[6:0] != SPCP_DEV_ADDR |=> st_q == SPCP_IDLE && sda_oe_n_q) else $error("foreign address taken");
  ack_drive_a: assert property (st_q == SPCP_ACK_W && scl_fall && sda_oe_n_q && !bus_stop
    |=> !sda_oe_n_q) else $error("write data not acknowledged");
  lock_read_a: assert property (st_q == SPCP_RDATA && bit_q == 3'h0 && ptr_ok_q && ptr_q == SPCP_IDX_CMD
    |-> sh_q[7]) else $error("lock bit read as zero");
  amb_set_a: assert property (amb_res.done |=> amb_rdy_q) else $error("ambient ready not set");
  amb_clear_a: assert property (clr_amb && !amb_res.done |=> !amb_rdy_q) else $error("ambient ready kept");
  dist_clear_a: assert property (clr_dist && !dist_res.done |=> !dist_rdy_q) else $error("distance ready kept");
  amb_oneshot_a: assert property (amb_os_q && !amb_busy |=> amb_start ##1 !amb_start)
    else $error("ambient one-shot lost");
  both_oneshot_a: assert property (amb_os_q && dist_os_q && !amb_busy && !dist_busy
    |=> amb_start && dist_start) else $error("one-shots not simultaneous");
  os_ignored_a: assert property ((amb_os_q || dist_os_q) |-> !cfg_q.selftimed)
    else $error("one-shot in self-timed mode");
  no_enable_a: assert property (cfg_q.selftimed && !cfg_q.amb_en |=> !amb_start)
    else $error("ambient started without enable");
  int_low_a: assert property ((amb_rdy_q || dist_rdy_q) |-> !int_oe_n_q && !int_out)
    else $error("interrupt not pulled low");

  write_cmd_c: cover property (st_q == SPCP_ACK_W && ptr_q == SPCP_IDX_CMD ##1 amb_os_q);
  read_res_c: cover property (clr_amb ##[1:400] st_q == SPCP_RACK);
  both_start_c: cover property (amb_start && dist_start);
  periodic_c: cover property (cfg_q.selftimed && dist_start);

endmodule // spcp_top

// ==== rtl/spcp_pkg.sv ====
// Package for the sensor command port: register map, field positions, timing and shared types.
// Assumes a 40 MHz system clock; all users import the whole package.
package spcp_pkg;

  // ------------------------------------------------------------------
  // Bus address and register map
  // ------------------------------------------------------------------
  // Fixed 7-bit target address; the direction bit makes 26h/27h on the wire.
  localparam logic [6:0] SPCP_DEV_ADDR = 7'h13;
  // First register address; the window runs contiguously from here.
  localparam logic [7:0] SPCP_REG_BASE = 8'h80;
  // Number of byte registers behind the bus.
  localparam int SPCP_REG_COUNT = 17;
  localparam logic [4:0] SPCP_IDX_CMD = 5'h00;
  localparam logic [4:0] SPCP_IDX_ID = 5'h01;
  localparam logic [4:0] SPCP_IDX_AMB_HI = 5'h05;
  localparam logic [4:0] SPCP_IDX_AMB_LO = 5'h06;
  localparam logic [4:0] SPCP_IDX_DIST_HI = 5'h07;
  localparam logic [4:0] SPCP_IDX_DIST_LO = 5'h08;
  localparam logic [4:0] SPCP_IDX_LAST = 5'h10;

  // ------------------------------------------------------------------
  // Command register fields
  // ------------------------------------------------------------------
  localparam int SPCP_LOCK_BIT = 7;
  localparam int SPCP_AMB_RDY_BIT = 6;
  localparam int SPCP_DIST_RDY_BIT = 5;
  localparam int SPCP_AMB_OS_BIT = 4;
  localparam int SPCP_DIST_OS_BIT = 3;
  localparam int SPCP_AMB_EN_BIT = 2;
  localparam int SPCP_DIST_EN_BIT = 1;
  localparam int SPCP_SELF_BIT = 0;
  // Reset value of the plain storage registers.
  localparam logic [7:0] SPCP_STORE_RESET = 8'h00;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int SPCP_MCLK_NS = 25;
  // Period of the self-timed scheduling tick, in nanoseconds.
  localparam int SPCP_LP_PERIOD_NS = 1000000;
  // Cycles per tick; a period, so it rounds down.
  localparam int SPCP_LP_CYCLES = SPCP_LP_PERIOD_NS / SPCP_MCLK_NS;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  // Self-timed configuration held in the command register.
  typedef struct packed {
    logic selftimed;
    logic amb_en;
    logic dist_en;
  } spcp_cfg_t;

  // Result from a converter: done pulse with its 16-bit value.
  typedef struct packed {
    logic done;
    logic [15:0] data;
  } spcp_res_t;

  // Target-side transfer states.
  typedef enum logic [3:0] {
    SPCP_IDLE, SPCP_ADDR, SPCP_ACK_A, SPCP_REGA, SPCP_ACK_R,
    SPCP_WDATA, SPCP_ACK_W, SPCP_RDATA, SPCP_RACK
  } spcp_state_t;

endpackage

// ==== rtl/spcp_seq.sv ====
// Measurement scheduler: turns one-shot requests and the self-timed tick into converter starts.
// Assumes done pulses come from converter logic on the same clock.
`timescale 1ns/1ps
module spcp_seq import spcp_pkg::*; #(
  parameter int LP_CYCLES = SPCP_LP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input spcp_cfg_t cfg,
  input wire logic amb_os,
  input wire logic dist_os,
  input wire logic amb_done,
  input wire logic dist_done,
  output logic amb_start,
  output logic dist_start,
  output logic amb_busy,
  output logic dist_busy
);

  // ------------------------------------------------------------------
  // Low-power tick divider and start logic
  // ------------------------------------------------------------------
  logic [31:0] div_q, div_d; // Tick divider, idle while self-timed mode is off.
  logic tick; // One-cycle scheduling enable.
  logic amb_start_d, dist_start_d, amb_busy_d, dist_busy_d;

  // The divider only runs with the scheduler enabled, standing in for the oscillator.
  always_comb begin
    tick = cfg.selftimed && (div_q == 32'(LP_CYCLES - 1));
    if (!cfg.selftimed || tick) begin
      div_d = 32'h0;
    end else begin
      div_d = div_q + 32'h1;
    end
    amb_start_d = (amb_os || (tick && cfg.amb_en)) && !amb_busy;
    dist_start_d = (dist_os || (tick && cfg.dist_en)) && !dist_busy;
    // A request during a running conversion is dropped rather than queued.
    amb_busy_d = amb_start_d || (amb_busy && !amb_done);
    dist_busy_d = dist_start_d || (dist_busy && !dist_done);
  end

  // Registers of the scheduler.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_q <= 32'h0;
      amb_start <= 1'b0;
      dist_start <= 1'b0;
      amb_busy <= 1'b0;
      dist_busy <= 1'b0;
    end else begin
      div_q <= div_d;
      amb_start <= amb_start_d;
      dist_start <= dist_start_d;
      amb_busy <= amb_busy_d;
      dist_busy <= dist_busy_d;
    end
  end

endmodule // spcp_seq

// ==== testbench/spcp_host_model.sv ====
// Bus controller model that plays the host side of the serial port.
// Assumes the bench resolves the open-drain data wire and feeds it back here.
`timescale 1ns/1ps
module spcp_host_model (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // Both lines are released at time zero, so the bus is idle at reset.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Waits four clock cycles, half of one 200 ns bus clock period.
  task automatic half();
    repeat (4) @(negedge mclk);
  endtask

  // Data changes one cycle after the clock falls so both never move together.
  task automatic bit_io(input logic b, output logic s);
    @(negedge mclk);
    sda_pull = !b;
    repeat (3) @(negedge mclk);
    scl = 1'b1;
    half();
    s = sda;
    scl = 1'b0;
  endtask

  // Start condition: data falls while the clock is high.
  task automatic start();
    @(negedge mclk);
    sda_pull = 1'b0;
    repeat (3) @(negedge mclk);
    scl = 1'b1;
    half();
    sda_pull = 1'b1;
    half();
    scl = 1'b0;
  endtask

  // Stop condition: data rises while the clock is high.
  task automatic stop();
    @(negedge mclk);
    sda_pull = 1'b1;
    repeat (3) @(negedge mclk);
    scl = 1'b1;
    half();
    sda_pull = 1'b0;
    half();
  endtask

  // Sends eight bits, most significant first, then samples the target's answer.
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask

  // Takes one byte and answers with a not-acknowledge, since one byte is all we read.
  task automatic get(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, s);
  endtask

  task automatic write_reg(input logic [7:0] dev, input logic [7:0] ra, input logic [7:0] d,
                           output logic [2:0] acks);
    start();
    put(dev, acks[2]);
    put(ra, acks[1]);
    put(d, acks[0]);
    stop();
  endtask

  task automatic read_reg(input logic [7:0] ra, output logic [7:0] d, output logic [2:0] acks);
    start();
    put(8'h26, acks[2]);
    put(ra, acks[1]);
    stop();
    start();
    put(8'h27, acks[0]);
    get(d);
    stop();
  endtask
endmodule // spcp_host_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the sensor command port, driven through the serial bus.
// Assumes the converters are stood in for by the bench through the result inputs.
`timescale 1ns/1ps
module tb_top;
  import spcp_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic sda_pull;
  logic sda_out;
  logic sda_oe_n;
  logic int_out;
  logic int_oe_n;
  logic amb_start;
  logic dist_start;
  spcp_res_t amb_res = '0;
  spcp_res_t dist_res = '0;
  int fail_count = 0;
  int n_tests = 0;
  int amb_cnt = 0;
  int dist_cnt = 0;
  int cyc = 0;
  // Pull-ups make each wire high unless some party pulls it low.
  wire sda = !(sda_pull || (!sda_oe_n && !sda_out));
  wire int_wire = !(!int_oe_n && !int_out);

  always #12.5 mclk = !mclk;

  spcp_host_model u_spcp_host_model (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  // Identity value is arbitrary; the bench sets it so that it can expect it back.
  localparam logic [7:0] id_value = 8'h5a;
  // A short tick keeps the self-timed scenario brief.
  spcp_top #(.LP_CYCLES(50), .ID_VALUE(id_value)) u_spcp_top (.mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_out(int_out), .int_oe_n(int_oe_n),
    .amb_start(amb_start), .dist_start(dist_start), .amb_res(amb_res), .dist_res(dist_res));

  // Counts start pulses so that single pulses and suppressed starts both show.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (amb_start === 1'b1) amb_cnt <= amb_cnt + 1;
    if (dist_start === 1'b1) dist_cnt <= dist_cnt + 1;
    if (cyc == 60000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    logic [2:0] a;
    u_spcp_host_model.write_reg(8'h26, ra, d, a);
    check("write acks", 16'h0007, {13'h0, a});
  endtask

  task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
    logic [2:0] a;
    logic [7:0] d;
    u_spcp_host_model.read_reg(ra, d, a);
    check("read acks", 16'h0007, {13'h0, a});
    check("read data", {8'h0, exp}, {8'h0, d});
  endtask

  // Converter stand-in: one-cycle done pulse with the result beside it.
  task automatic done(input logic amb, input logic [15:0] v);
    @(negedge mclk);
    if (amb) amb_res = '{done: 1'b1, data: v};
    else dist_res = '{done: 1'b1, data: v};
    @(negedge mclk);
    amb_res.done = 1'b0;
    dist_res.done = 1'b0;
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_map();
    logic [2:0] a;
    rd(8'h80, 8'h80);
    rd(8'h91, 8'h00);
    u_spcp_host_model.write_reg(8'h28, 8'h82, 8'hff, a);
    check("foreign address acks", 16'h0, {13'h0, a});
    wr(8'h82, 8'ha5);
    rd(8'h82, 8'ha5);
    wr(8'h90, 8'h3c);
    rd(8'h90, 8'h3c);
    wr(8'h81, 8'h00);
    rd(8'h81, id_value);
    wr(8'h85, 8'hff);
    rd(8'h85, 8'h00);
    wr(8'h80, 8'he0);
    rd(8'h80, 8'h80);
  endtask

  task automatic t_amb();
    int c;
    c = amb_cnt;
    wr(8'h80, 8'h10);
    check("ambient starts", 16'(c + 1), 16'(amb_cnt));
    rd(8'h80, 8'h90);
    done(1'b1, 16'h1234);
    check("interrupt wire", 16'h0, {15'h0, int_wire});
    rd(8'h80, 8'hc0);
    rd(8'h85, 8'h12);
    rd(8'h80, 8'h80);
    check("interrupt wire", 16'h1, {15'h0, int_wire});
    rd(8'h86, 8'h34);
  endtask

  task automatic t_both();
    int c;
    int e;
    c = amb_cnt;
    e = dist_cnt;
    wr(8'h80, 8'h18);
    check("both starts", 16'(c + e + 2), 16'(amb_cnt + dist_cnt));
    rd(8'h80, 8'h98);
    done(1'b0, 16'habcd);
    done(1'b1, 16'h0102);
    rd(8'h80, 8'he0);
    rd(8'h88, 8'hcd);
    rd(8'h80, 8'hc0);
    rd(8'h87, 8'hab);
    rd(8'h86, 8'h02);
    rd(8'h80, 8'h80);
  endtask

  task automatic t_self();
    int c;
    c = amb_cnt + dist_cnt;
    wr(8'h80, 8'h01);
    repeat (150) @(negedge mclk);
    check("idle self-timed starts", 16'(c), 16'(amb_cnt + dist_cnt));
    rd(8'h80, 8'h81);
    wr(8'h80, 8'h19);
    check("ignored one-shot starts", 16'(c), 16'(amb_cnt + dist_cnt));
    wr(8'h80, 8'h07);
    repeat (120) @(negedge mclk);
    check("periodic starts", 16'(c + 2), 16'(amb_cnt + dist_cnt));
    rd(8'h80, 8'h9f);
    wr(8'h80, 8'h00);
    done(1'b1, 16'h5555);
    done(1'b0, 16'haaaa);
    rd(8'h80, 8'he0);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_map();
    t_amb();
    t_both();
    t_self();
    print_verdict();
  end
endmodule // tb_top
